/* File: design/drpaf_map.vh */
`ifndef DRPAF_MAP_VH
`define DRPAF_MAP_VH
// ****************************************
// Timing
// ****************************************
`define DRPAF_CLK_MHZ 125
// Attach debounce time in microseconds
`define DRPAF_T_CC_DEB_US 150
// Detach observation time in microseconds
`define DRPAF_T_VPD_DET_US 20
// Half period of the unattached role toggle in microseconds
`define DRPAF_T_TOGGLE_US 50
// Cycle counts derived from the rate
`define DRPAF_CC_DEB_CYC (`DRPAF_T_CC_DEB_US * `DRPAF_CLK_MHZ)
`define DRPAF_VPD_DET_CYC (`DRPAF_T_VPD_DET_US * `DRPAF_CLK_MHZ)
`define DRPAF_TOGGLE_CYC (`DRPAF_T_TOGGLE_US * `DRPAF_CLK_MHZ)
`define DRPAF_CNT_W 24
// ****************************************
// Port capability codes
// ****************************************
`define DRPAF_CAP_DRP 2'h0
`define DRPAF_CAP_SRC 2'h1
`define DRPAF_CAP_SNK 2'h2
// ****************************************
// Rp current levels
// ****************************************
`define DRPAF_RP_DEF 2'h0
`define DRPAF_RP_1A5 2'h1
`define DRPAF_RP_3A0 2'h2
// ****************************************
// Identity reply codes
// ****************************************
`define DRPAF_ID_OTHER 2'h0
`define DRPAF_ID_VPD 2'h1
`define DRPAF_ID_CTVPD 2'h2
`endif

/* File: design/drpaf_debounce.v */
`timescale 1ns/10ps
`include "drpaf_map.vh"
// ****************************************
// Stable-level timer: counts while a condition holds unchanged
// ****************************************
module drpaf_debounce
(
   input wire mclk,
   input wire rst,
   input wire clear,
   input wire cond,
   input wire [`DRPAF_CNT_W-1:0] limit,
   output reg done_q
);
   // Elapsed cycles of unchanged condition
   reg [`DRPAF_CNT_W-1:0] cnt_q;
   // Last seen condition, to detect a change
   reg cond_q;

   // ****************************************
   // Counter
   // ****************************************
   // Restarts on any change or clear; done only while cond is true
   always @(posedge mclk)
   begin
      if (rst || clear)
      begin
         cnt_q <= {`DRPAF_CNT_W{1'b0}};
         cond_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (cond != cond_q)
      begin
         // Change seen: restart the interval
         cnt_q <= {`DRPAF_CNT_W{1'b0}};
         cond_q <= cond;
         done_q <= 1'b0;
      end
      else if (cond && cnt_q < limit)
      begin
         cnt_q <= cnt_q + 1'b1;
         done_q <= (cnt_q + 1'b1 >= limit);
      end
   end
endmodule // drpaf_debounce

/* File: design/drpaf_attach_fsm.v */
`timescale 1ns/10ps
`include "drpaf_map.vh"
module drpaf_attach_fsm
(
   input wire mclk,
   input wire rst,
   input wire [1:0] port_cap,
   input wire prefer_sink,
   input wire vpd_support,
   input wire [1:0] rp_level,
   // CC and supply sense, taken as already synchronous to mclk
   input wire cc_pullup_seen,
   input wire cc_pulldown_seen,
   input wire vbus_seen,
   input wire id_reply_valid,
   input wire [1:0] id_reply_kind,
   // Registered terminations and supply switches
   output reg cc_rp_en_q,
   output reg cc_rd_en_q,
   output reg [1:0] cc_rp_level_q,
   output reg vbus_en_q,
   output reg vconn_en_q,
   output reg id_query_q,
   output reg [3:0] state_q
);
   // ****************************************
   // States
   // ****************************************
   // Codes are exported on state_q, so keep them stable
   localparam [3:0] ST_UNATT_SNK = 4'h0;
   localparam [3:0] ST_UNATT_SRC = 4'h1;
   localparam [3:0] ST_AWAIT_SNK = 4'h2;
   localparam [3:0] ST_AWAIT_SRC = 4'h3;
   localparam [3:0] ST_TRY_SNK = 4'h4;
   localparam [3:0] ST_ATT_SNK = 4'h5;
   localparam [3:0] ST_ATT_SRC = 4'h6;
   localparam [3:0] ST_VPD_SRC = 4'h7;
   localparam [3:0] ST_CT_UNATT_SNK = 4'h8;
   localparam [3:0] ST_CT_ATT_SNK = 4'h9;

   // Full-width interval counts, kept as integers for the cut below
   localparam integer DEB_FULL = `DRPAF_CC_DEB_CYC;
   localparam integer DET_FULL = `DRPAF_VPD_DET_CYC;
   localparam integer TOG_FULL = `DRPAF_TOGGLE_CYC;
   // Interval limits, cut to counter width on purpose; all counts fit well inside it
   localparam [`DRPAF_CNT_W-1:0] LIM_DEB = DEB_FULL[`DRPAF_CNT_W-1:0];
   localparam [`DRPAF_CNT_W-1:0] LIM_DET = DET_FULL[`DRPAF_CNT_W-1:0];
   localparam [`DRPAF_CNT_W-1:0] LIM_TOG = TOG_FULL[`DRPAF_CNT_W-1:0];

   // ****************************************
   // Internal signals
   // ****************************************
   // Next-state value
   reg [3:0] state_d;
   // Toggle timer for the unattached alternation
   reg [`DRPAF_CNT_W-1:0] tog_q;
   // Query already issued in this attachment
   reg queried_q;
   // Timer clear on every state change
   wire st_chg;
   // Debounced pull-down, pull-up and detach
   wire pd_done;
   wire pu_done;
   wire det_done;
   // Detach of a charge-through partner: neither VBUS nor pull-up
   wire ct_gone;

   // Any state change restarts every interval timer
   assign st_chg = (state_d != state_q);
   // Both supply and pull-up must be gone before the detach timer runs
   assign ct_gone = !vbus_seen && !cc_pullup_seen;

   // ****************************************
   // Debounce timers
   // ****************************************
   // Each restarts whenever its watched level flips
   // Partner pull-down, for the source-side attach
   drpaf_debounce u_pd_deb
   (
      .mclk(mclk),
      .rst(rst),
      .clear(st_chg),
      .cond(cc_pulldown_seen),
      .limit(LIM_DEB),
      .done_q(pd_done)
   );
   // Partner pull-up, for the sink-side attach
   drpaf_debounce u_pu_deb
   (
      .mclk(mclk),
      .rst(rst),
      .clear(st_chg),
      .cond(cc_pullup_seen),
      .limit(LIM_DEB),
      .done_q(pu_done)
   );
   // Charge-through partner gone, for the detach interval
   drpaf_debounce u_det_deb
   (
      .mclk(mclk),
      .rst(rst),
      .clear(st_chg),
      .cond(ct_gone),
      .limit(LIM_DET),
      .done_q(det_done)
   );

   // ****************************************
   // Role toggle timer
   // ****************************************
   // Only a dual-role port alternates; fixed roles stay put
   // Cleared on every state change so each unattached state gets a full half period
   // Saturates at the limit, so a long stay never wraps into a false toggle
   always @(posedge mclk)
   begin
      if (rst || st_chg)
         tog_q <= {`DRPAF_CNT_W{1'b0}};
      else if (tog_q < LIM_TOG)
         tog_q <= tog_q + 1'b1;
   end

   // ****************************************
   // Next state
   // ****************************************
   always @*
   begin
      state_d = state_q;
      case (state_q)
         // Sink side of the unattached alternation
         ST_UNATT_SNK:
         begin
            // Source-only ports never sit on the sink side
            if (port_cap == `DRPAF_CAP_SRC)
               state_d = ST_UNATT_SRC;
            else if (cc_pullup_seen)
               state_d = ST_AWAIT_SNK;
            else if (port_cap == `DRPAF_CAP_DRP && tog_q >= LIM_TOG)
               state_d = ST_UNATT_SRC;
            // A sink-only port with no pull-up stays here
         end
         // Source side of the unattached alternation
         ST_UNATT_SRC:
         begin
            // Sink-only ports never sit on the source side
            if (port_cap == `DRPAF_CAP_SNK)
               state_d = ST_UNATT_SNK;
            else if (cc_pulldown_seen)
               state_d = ST_AWAIT_SRC;
            else if (port_cap == `DRPAF_CAP_DRP && tog_q >= LIM_TOG)
               state_d = ST_UNATT_SNK;
            // A source-only port with no pull-down stays here
         end
         // Partner pull-up seen, waiting for it to settle
         ST_AWAIT_SNK:
         begin
            // Pull-up lost: back to the sink side
            if (!cc_pullup_seen)
               state_d = ST_UNATT_SNK;
            // Pull-up stable and supply up: attach as sink
            else if (pu_done && vbus_seen)
               state_d = ST_ATT_SNK;
         end
         // Partner pull-down seen, debounce running
         ST_AWAIT_SRC:
         begin
            // Pull-down lost before the interval ran out
            if (!cc_pulldown_seen)
               state_d = ST_UNATT_SNK;
            else if (pd_done && prefer_sink && port_cap == `DRPAF_CAP_DRP)
               state_d = ST_TRY_SNK;
            else if (pd_done)
               state_d = ST_ATT_SRC;
         end
         // Limitation: no timeout, a partner that never sources holds us here
         ST_TRY_SNK:
         begin
            // Pull-up alone keeps waiting; VBUS completes the swap
            if (vbus_seen)
               state_d = ST_ATT_SNK;
            else
               state_d = ST_TRY_SNK;
         end
         // Attached as sink; supply loss is the only detach sign
         ST_ATT_SNK:
         begin
            if (!vbus_seen)
               state_d = ST_UNATT_SNK;
         end
         // Attached as source; waits for the identity reply
         ST_ATT_SRC:
         begin
            if (!cc_pulldown_seen)
               state_d = ST_UNATT_SNK;
            // A reply of any other kind leaves the attachment as it is
            else if (id_reply_valid && id_reply_kind == `DRPAF_ID_VPD)
               state_d = ST_VPD_SRC;
            else if (id_reply_valid && id_reply_kind == `DRPAF_ID_CTVPD)
               state_d = ST_CT_UNATT_SNK;
         end
         // Supply off for a partner powered from VCONN, Rp kept
         ST_VPD_SRC:
         begin
            if (!cc_pulldown_seen)
               state_d = ST_UNATT_SNK;
         end
         // Sink terminations towards a charge-through partner
         ST_CT_UNATT_SNK:
         begin
            // Detach timer is checked first, so a stale supply cannot hold the state
            if (det_done)
               state_d = ST_UNATT_SNK;
            else if (vbus_seen)
               state_d = ST_CT_ATT_SNK;
         end
         // Charge-through supply present
         ST_CT_ATT_SNK:
         begin
            // Loss of charge-through supply falls back one level
            if (!vbus_seen)
               state_d = ST_CT_UNATT_SNK;
         end
         // Unused codes fall back to the idle state
         default:
            state_d = ST_UNATT_SNK;
      endcase
   end

   // ****************************************
   // State and registered outputs
   // ****************************************
   // Outputs decoded from the next state so they change with it
   always @(posedge mclk)
   begin
      if (rst)
      begin
         state_q <= ST_UNATT_SNK;
         cc_rp_en_q <= 1'b0;
         // Pull-down from reset, so an idle port reads as a sink
         cc_rd_en_q <= 1'b1;
         cc_rp_level_q <= `DRPAF_RP_DEF;
         vbus_en_q <= 1'b0;
         vconn_en_q <= 1'b0;
         // No query pending and no attachment remembered
         id_query_q <= 1'b0;
         queried_q <= 1'b0;
      end
      else
      begin
         // Next state
         state_q <= state_d;
         // Pull-up terminations for every source-facing state
         cc_rp_en_q <= (state_d == ST_UNATT_SRC) || (state_d == ST_AWAIT_SRC) ||
                       (state_d == ST_ATT_SRC) || (state_d == ST_VPD_SRC);
         // Pull-down in sink states, Try.SNK and charge-through sink
         cc_rd_en_q <= (state_d == ST_UNATT_SNK) || (state_d == ST_AWAIT_SNK) ||
                       (state_d == ST_TRY_SNK) || (state_d == ST_ATT_SNK) ||
                       (state_d == ST_CT_UNATT_SNK) || (state_d == ST_CT_ATT_SNK);
         // Current cap follows software level in every state, sourcing or not
         cc_rp_level_q <= rp_level;
         // Supply only in the plain attached source state
         vbus_en_q <= (state_d == ST_ATT_SRC);
         // VCONN stays on through the charge-through states
         vconn_en_q <= (state_d == ST_ATT_SRC) || (state_d == ST_VPD_SRC) ||
                       (state_d == ST_CT_UNATT_SNK) || (state_d == ST_CT_ATT_SNK);
         // One identity query per attachment, one-cycle pulse
         id_query_q <= 1'b0;
         // Flag clears on leaving the source state, so a new attachment queries again
         if (state_d != ST_ATT_SRC)
            queried_q <= 1'b0;
         // Waits one cycle in the state so the cable has its supply first
         else if (vpd_support && !queried_q && state_q == ST_ATT_SRC)
         begin
            id_query_q <= 1'b1;
            queried_q <= 1'b1;
         end
      end
   end
endmodule // drpaf_attach_fsm

/* File: tb/drpaf_attach_fsm_monitor.sv */
`timescale 1ns/10ps
`include "drpaf_map.vh"
// ****************
// Attach FSM checker
// ****************
module drpaf_monitor
(
   input wire mclk,
   input wire rst,
   input wire vpd_support,
   input wire cc_pulldown_seen,
   input wire vbus_seen,
   input wire id_reply_valid,
   input wire [1:0] id_reply_kind,
   input wire cc_rp_en_q,
   input wire cc_rd_en_q,
   input wire vbus_en_q,
   input wire vconn_en_q,
   input wire id_query_q,
   input wire [3:0] state_q
);
   localparam int DEB = `DRPAF_CC_DEB_CYC; // Attach debounce
   int deb_n = 0; // Stable pull-down run in wait state
   // Run restarts on any break, as the design timer must
   always @(posedge mclk)
   begin
      deb_n <= (state_q == 4'h3 && cc_pulldown_seen) ? deb_n + 1 : 0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Entry into attached source
   sequence s_src_entry;
      state_q != 4'h6 ##1 state_q == 4'h6;
   endsequence
   // Identity reply while attached as source
   sequence s_reply(k);
      state_q == 4'h6 && id_reply_valid && id_reply_kind == k;
   endsequence
   a_try_pulls_down: assert property (state_q == 4'h4 |-> cc_rd_en_q && !cc_rp_en_q) else $error("try rd");
   a_try_to_sink: assert property (state_q == 4'h4 && vbus_seen |=> state_q == 4'h5) else $error("try vbus");
   a_src_powers: assert property (state_q == 4'h6 |-> vbus_en_q && vconn_en_q && cc_rp_en_q) else $error("src");
   a_src_detach: assert property ((state_q == 4'h6 || state_q == 4'h7) && !cc_pulldown_seen |=> state_q == 4'h0)
      else $error("src detach");
   a_snk_detach: assert property (state_q == 4'h5 && !vbus_seen |=> state_q == 4'h0) else $error("snk detach");
   a_query_once: assert property (s_src_entry ##0 vpd_support |=> id_query_q ##1 !id_query_q) else $error("query");
   a_vpd_drops: assert property (s_reply(`DRPAF_ID_VPD) |=> state_q == 4'h7 && !vbus_en_q && cc_rp_en_q)
      else $error("vpd");
   a_ct_to_rd: assert property (s_reply(`DRPAF_ID_CTVPD) |=> state_q == 4'h8 && !vbus_en_q && cc_rd_en_q
      && !cc_rp_en_q && vconn_en_q) else $error("ct");
   a_deb_full: assert property (state_q == 4'h3 && cc_pulldown_seen && deb_n < DEB - 4 |=> state_q == 4'h3)
      else $error("debounce short");
   a_deb_bound: assert property (state_q == 4'h3 |-> deb_n <= DEB + 4) else $error("debounce long");
   a_query_gated: assert property (id_query_q |-> $past(vpd_support) && state_q == 4'h6) else $error("query gate");
endmodule // drpaf_monitor
bind drpaf_attach_fsm drpaf_monitor u_drpaf_monitor (.mclk, .rst, .vpd_support, .cc_pulldown_seen, .vbus_seen,
   .id_reply_valid, .id_reply_kind, .cc_rp_en_q, .cc_rd_en_q, .vbus_en_q, .vconn_en_q, .id_query_q, .state_q);

/* File: tb/drpaf_far_model.sv */
`timescale 1ns/10ps
`include "drpaf_map.vh"
// ****************
// Far port: DRP, VPD or CT device
// ****************
module drpaf_far_model
(
   input wire mclk,
   input wire rst,
   input wire plugged,
   input wire [1:0] kind,
   input wire [5:0] delay,
   input wire rp_in,
   input wire rd_in,
   input wire vbus_in,
   input wire vconn_in,
   input wire query,
   input wire ct_power,
   output wire pu,
   output wire pd,
   output reg vbus,
   output reg rv,
   output wire [1:0] rk
);
   reg seen_q; // Host pull-up seen
   reg src_q; // Turned source
   reg ct_q; // CT host port now Rp
   reg done_q; // Reply sent
   reg [5:0] cnt_q; // Reply or VBUS delay
   assign rk = kind;
   assign pd = plugged && !src_q && !ct_q;
   assign pu = plugged && (src_q || ct_q);
   // Unplug drops every line at once
   always @(posedge mclk)
   begin
      rv <= 1'b0;
      if (rst || !plugged)
         {seen_q, src_q, ct_q, done_q, vbus, cnt_q} <= 11'h000;
      else
      begin
         seen_q <= seen_q || rp_in;
         if (kind == `DRPAF_ID_OTHER && seen_q && !rp_in && rd_in)
            src_q <= 1'b1;
         if (kind == `DRPAF_ID_CTVPD && done_q && vconn_in && !vbus_in && rd_in)
            ct_q <= 1'b1;
         if (src_q)
         begin
            cnt_q <= cnt_q + 6'h01;
            vbus <= vbus || cnt_q == delay;
         end
         else if (query && vconn_in && kind != `DRPAF_ID_OTHER && !ct_power)
            cnt_q <= delay;
         else if (cnt_q != 6'h00)
         begin
            cnt_q <= cnt_q - 6'h01;
            rv <= cnt_q == 6'h01;
            done_q <= done_q || cnt_q == 6'h01;
         end
         // Charge-through pins stay open until the host side turns sink; then the far supply passes
         if (ct_q)
            vbus <= ct_power;
         // Host supply gone: back to the unattached sink state
         if (ct_q && !vconn_in)
         begin
            ct_q <= 1'b0;
            done_q <= 1'b0;
         end
      end
   end
endmodule // drpaf_far_model

/* File: tb/drpaf_attach_fsm_test.sv */
`timescale 1ns/10ps
`include "drpaf_map.vh"
// ****************
// Attach FSM bench
// ****************
module drpaf_attach_fsm_test;
   reg mclk = 1'b0; // 125 MHz
   reg rst = 1'b1;
   reg [1:0] port_cap = `DRPAF_CAP_SRC;
   reg prefer_sink = 1'b0;
   reg [1:0] rp_level = `DRPAF_RP_3A0;
   reg plugged = 1'b0; // Far side present
   reg [1:0] kind = `DRPAF_ID_OTHER;
   reg [5:0] delay = 6'h01; // Slow or prompt far side
   reg vpd_support = 1'b1; // Identity query enable
   reg ct_power = 1'b0; // Source on the far charge-through side
   wire pu, pd, vb, rv, rp_en, rd_en, vbus_en, vconn_en, query;
   wire [1:0] rk;
   wire [1:0] lvl;
   wire [3:0] st;
   int bad_count = 0;
   int compares = 0;
   initial forever #4 mclk = ~mclk;
   drpaf_attach_fsm u_drpaf_attach_fsm (.mclk(mclk), .rst(rst), .port_cap(port_cap), .prefer_sink(prefer_sink),
      .vpd_support(vpd_support), .rp_level(rp_level), .cc_pullup_seen(pu), .cc_pulldown_seen(pd), .vbus_seen(vb),
      .id_reply_valid(rv), .id_reply_kind(rk), .cc_rp_en_q(rp_en), .cc_rd_en_q(rd_en), .cc_rp_level_q(lvl),
      .vbus_en_q(vbus_en), .vconn_en_q(vconn_en), .id_query_q(query), .state_q(st));
   drpaf_far_model u_drpaf_far_model (.mclk(mclk), .rst(rst), .plugged(plugged), .kind(kind), .delay(delay),
      .rp_in(rp_en), .rd_in(rd_en), .vbus_in(vbus_en), .vconn_in(vconn_en), .query(query), .pu(pu), .pd(pd),
      .vbus(vb), .rv(rv), .rk(rk), .ct_power(ct_power));
   task chk(input [7:0] got, input [7:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %0t: saw %h want %h", $time, got, exp);
      end
   endtask
   // Bounded wait; a hang counts as a mismatch
   task wait_st(input [3:0] s, input int lim);
      int n;
      n = 0;
      while (st !== s && n < lim)
      begin
         @(negedge mclk);
         n = n + 1;
      end
      chk(st, s);
      if (st !== s)
         end_of_test();
   endtask
   task do_reset;
      rst = 1'b1;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
   endtask
   // Lone source and lone sink never leave their idle state
   task t_lone;
      do_reset();
      repeat (300) @(negedge mclk);
      chk(st, 4'h1);
      port_cap = `DRPAF_CAP_SNK;
      do_reset();
      repeat (300) @(negedge mclk);
      chk({st, rp_en}, 5'h00);
   endtask
   // Prompt VPD: attach, query, VBUS off, then detach
   task t_vpd;
      port_cap = `DRPAF_CAP_DRP;
      kind = `DRPAF_ID_VPD;
      vpd_support = 1'b0;
      plugged = 1'b1;
      do_reset();
      wait_st(4'h6, 30000);
      chk({vbus_en, vconn_en, rp_en, lvl}, 5'h1e);
      repeat (3) @(negedge mclk);
      chk({st, query}, 5'h0c);
      vpd_support = 1'b1;
      @(negedge mclk);
      chk(query, 1'b1);
      wait_st(4'h7, 40);
      chk({vbus_en, rp_en}, 2'h1);
      plugged = 1'b0;
      wait_st(4'h0, 10);
   endtask
   // Slow CT device, then timed detach
   task t_ct;
      kind = `DRPAF_ID_CTVPD;
      delay = 6'h0f;
      plugged = 1'b1;
      wait_st(4'h6, 30000);
      rp_level = `DRPAF_RP_1A5;
      @(negedge mclk);
      chk(lvl, `DRPAF_RP_1A5);
      wait_st(4'h8, 40);
      chk({vbus_en, vconn_en, rp_en, rd_en}, 4'h5);
      repeat (2600) @(negedge mclk);
      chk(st, 4'h8);
      ct_power = 1'b1;
      wait_st(4'h9, 10);
      chk({vbus_en, vconn_en, rp_en, rd_en}, 4'h5);
      ct_power = 1'b0;
      wait_st(4'h8, 10);
      plugged = 1'b0;
      repeat (2490) @(negedge mclk);
      chk(st, 4'h8);
      wait_st(4'h0, 30);
   endtask
   // Sink preference against a DRP partner
   task t_try;
      kind = `DRPAF_ID_OTHER;
      delay = 6'h32;
      prefer_sink = 1'b1;
      plugged = 1'b1;
      wait_st(4'h4, 30000);
      chk({rp_en, rd_en}, 2'h1);
      repeat (20) @(negedge mclk);
      chk({st, pu}, 5'h09);
      wait_st(4'h5, 60);
      plugged = 1'b0;
      wait_st(4'h0, 10);
   endtask
   task end_of_test;
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      t_lone();
      t_vpd();
      t_ct();
      t_try();
      end_of_test();
   end
endmodule // drpaf_attach_fsm_test
